// ===== sim/dmc_diag_ctrl_monitor.sv
// Assertion checker for the diagnostic control block
module dmc_diag_ctrl_monitor #(
  parameter NCELL     = 14,
  parameter SETTLE    = 10,
  parameter SHUT_CODE = 14'h3000
) (
  input logic             clk,
  input logic             rst,
  input logic [3:0]       addr,
  input logic [15:0]      wdata,
  input logic             wr,
  input logic             rd,
  input logic [15:0]      rdata_q,
  input logic             alert_any,
  input logic [13:0]      die_temp_code,
  input logic             meas_cycle_start,
  input logic             alert_out_pin_q,
  input logic             alert_out_oe_q,
  input logic [NCELL-1:0] pulldown_en_q,
  input logic             shutdown_q,
  input logic [3:0]       adc_mux_sel_q,
  input logic             adc_ref_analog_q,
  input logic             adc_force_unipolar_q,
  input logic [11:0]      threshold_dac_q,
  input logic             diag_conv_go_q
);
  // ----------------------------------------
  // Shadow control bits, settle counter
  // ----------------------------------------
  logic [3:0]  ctl_q;
  logic [15:0] cnt_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= 4'h0;
      cnt_q <= 16'h0000;
    end else begin
      if (wr && addr == 4'h0)
        ctl_q <= wdata[3:0];
      if (meas_cycle_start)
        cnt_q <= 16'h0001;
      // Go pulse lands one edge after the countdown ends
      else if (cnt_q != 16'h0000 && cnt_q < SETTLE + 2)
        cnt_q <= cnt_q + 16'h0001;
      else
        cnt_q <= 16'h0000;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_oe_from_ctrl: assert property (
    alert_out_oe_q == $past(ctl_q[0] & ctl_q[1])) else $error("dc test enable wrong");
  a_pin_follows_alert: assert property (
    alert_out_oe_q |-> alert_out_pin_q == !($past(alert_any) | $past(ctl_q[2])))
    else $error("alert pin level wrong");
  a_pulldown_gated: assert property (
    |pulldown_en_q |-> $past(ctl_q[3])) else $error("pulldown outside open mode");
  a_shutdown_hot: assert property (
    die_temp_code > SHUT_CODE |=> shutdown_q) else $error("no shutdown when hot");
  a_shutdown_held: assert property (
    shutdown_q |=> shutdown_q) else $error("shutdown released");
  a_settle_wait: assert property (
    diag_conv_go_q == (cnt_q == SETTLE + 2)) else $error("conversion start timing wrong");
  a_dac_full: assert property (
    $stable(adc_mux_sel_q) |->
      threshold_dac_q == (adc_mux_sel_q == 4'h4 ? 12'h3FF : 12'h000))
    else $error("threshold converter wrong");
  a_unipolar_alt: assert property (
    $stable(adc_mux_sel_q) |-> adc_force_unipolar_q == (adc_mux_sel_q == 4'h3))
    else $error("unipolar force wrong");
  a_ref_analog: assert property (
    $stable(adc_mux_sel_q) |-> adc_ref_analog_q == (adc_mux_sel_q == 4'h2))
    else $error("converter reference wrong");
  a_read_idle: assert property (
    !$past(rd) |-> rdata_q == 16'h0000) else $error("read data not idle");
  a_read_unmapped: assert property (
    $past(rd) && $past(addr) > 4'hB |-> rdata_q == 16'h0000) else $error("unmapped read");
endmodule

bind dmc_diag_ctrl dmc_diag_ctrl_monitor #(
  .NCELL(NCELL), .SETTLE(SETTLE), .SHUT_CODE(SHUT_CODE)
) dmc_diag_ctrl_monitor_inst (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
  .alert_any(alert_any), .die_temp_code(die_temp_code), .meas_cycle_start(meas_cycle_start),
  .alert_out_pin_q(alert_out_pin_q), .alert_out_oe_q(alert_out_oe_q),
  .pulldown_en_q(pulldown_en_q), .shutdown_q(shutdown_q), .adc_mux_sel_q(adc_mux_sel_q),
  .adc_ref_analog_q(adc_ref_analog_q), .adc_force_unipolar_q(adc_force_unipolar_q),
  .threshold_dac_q(threshold_dac_q), .diag_conv_go_q(diag_conv_go_q));

// ===== sim/test_dmc_diag_ctrl.sv
// Self-checking testbench for the diagnostic control block
`include "dmc_regs.vh"
module test_dmc_diag_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int NC = 14;
  localparam int ST = 10;
  localparam int TI = 50;
  logic             clk   = 1'h0;
  logic             rst   = 1'h1;
  logic [3:0]       addr  = 4'h0;
  logic [15:0]      wdata = 16'h0000;
  logic             wr    = 1'h0;
  logic             rd    = 1'h0;
  logic             alr   = 1'h0;
  logic [1:0]       cfg   = 2'h0;
  logic [NC-1:0]    cv    = '0;
  logic [12*NC-1:0] cval  = '0;
  logic             sd    = 1'h0;
  logic [13:0]      dtc   = 14'h0000;
  logic             ad    = 1'h0;
  logic [13:0]      ar    = 14'h0000;
  logic             ms    = 1'h0;
  logic [15:0]      rdata_q;
  logic             pin, oe, shut, refa, uni, go;
  logic [NC-1:0]    pd;
  logic [2:0]       lvl;
  logic [3:0]       msel;
  logic [11:0]      dac;
  logic [3:0]       codes [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'hD};
  int               errors = 0;
  int               checks_done = 0;
  int               seed = 71;

  dmc_diag_ctrl #(.NCELL(NC), .SETTLE(ST), .TEMP_INT(TI), .SHUT_CODE(14'h3000))
  dmc_diag_ctrl_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .alert_any(alr), .serial_iface_config(cfg), .comp_cell_valid(cv), .comp_cell_value(cval),
    .comp_scan_done(sd), .die_temp_code(dtc), .adc_done(ad), .adc_result(ar),
    .meas_cycle_start(ms), .alert_out_pin_q(pin), .alert_out_oe_q(oe), .pulldown_en_q(pd),
    .test_current_level_q(lvl), .shutdown_q(shut), .adc_mux_sel_q(msel),
    .adc_ref_analog_q(refa), .adc_force_unipolar_q(uni), .threshold_dac_q(dac),
    .diag_conv_go_q(go));

  always #5 clk = ~clk;
  // ----------------------------------------
  // Tasks and expectations
  // ----------------------------------------
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_r(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rd_r(logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    d = rdata_q;
  endtask
  task automatic conv(logic [13:0] v);
    @(posedge clk);
    ar <= v;
    ad <= 1'h1;
    @(posedge clk);
    ad <= 1'h0;
  endtask
  // Bounds as {low, high}; selects without a window always pass
  function automatic logic [27:0] wnd(logic [3:0] c);
    case (c)
      4'h2: return {14'h0A55, 14'h0BF4};
      4'h3: return {14'h3247, 14'h341F};
      4'hD: return {14'h2147, 14'h24B6};
      4'h4: return {14'h1F3F, 14'h20BB};
      default: return {14'h0000, 14'h3FFF};
    endcase
  endfunction
  function automatic logic ep(logic [3:0] c, logic [13:0] v);
    logic [27:0] w;
    w = wnd(c);
    return v >= w[27:14] && v <= w[13:0];
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [15:0] d;
    logic [13:0] r1, r2;
    logic [NC-1:0] bm, ce, ef;
    logic [3:0] c;
    int k;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    rd_r(`DMC_A_TEMP_TH, d); chk("temp threshold", 16'h3FFF, d);
    chk("pin reset", 16'h0001, 16'(pin));
    for (k = 12; k < 16; k++) begin
      wr_r(k[3:0], 16'hFFFF);
      rd_r(k[3:0], d); chk("unmapped", 16'h0000, d);
    end
    rd_r(`DMC_A_CTRL, d); chk("ctrl", 16'h0000, d);
    $display("reset and map test done");
    for (k = 0; k < 16; k++) begin
      wr_r(`DMC_A_CTRL, {13'h0, k[0], 1'h1, k[3]});
      @(posedge clk);
      alr <= k[1];
      cfg <= k[2:1];
      tick(3);
      chk("oe", 16'(k[3]), 16'(oe));
      if (k[3]) chk("pin", 16'(!(k[0] | k[1])), 16'(pin));
    end
    $display("alert pin test done");
    bm = 14'($random(seed)) & 14'h3FFC;
    ce = 14'($random(seed));
    wr_r(`DMC_A_OPEN_TH, 16'h0800);
    wr_r(`DMC_A_BIPOLAR, {2'h0, bm});
    wr_r(`DMC_A_CTST_EN, {2'h0, ce});
    wr_r(`DMC_A_DIAG_CONFIG_REG, 16'h0500);
    wr_r(`DMC_A_CTRL, 16'h0008);
    wr_r(`DMC_A_SCAN, 16'h0005);
    @(posedge clk);
    cv <= '1;
    for (k = 0; k < NC; k++) cval[12*k+:12] <= 12'($random(seed));
    cval[23:0] <= 24'h8007FF;
    @(posedge clk);
    cv <= '0;
    tick(1);
    chk("pulldown", {2'h0, ce}, {2'h0, pd});
    chk("level", 16'h0005, 16'(lvl));
    for (k = 0; k < NC; k++) ef[k] = !bm[k] && cval[12*k+:12] < 12'h800;
    rd_r(`DMC_A_COMP_OV, d); chk("open flags", {2'h0, ef}, d);
    @(posedge clk);
    sd <= 1'h1;
    @(posedge clk);
    sd <= 1'h0;
    tick(2);
    chk("pulldown off", 16'h0000, {2'h0, pd});
    wr_r(`DMC_A_COMP_OV, 16'h3FFF);
    rd_r(`DMC_A_COMP_OV, d); chk("flags cleared", 16'h0000, d);
    $display("open wire test done");
    for (k = 0; k < 5; k++) begin
      c = codes[k];
      wr_r(`DMC_A_DIAG_CONFIG_REG, {8'h00, c, c});
      tick(2);
      chk("mux", 16'(c), 16'(msel));
      chk("ref", 16'(c == 4'h2), 16'(refa));
      chk("unipolar", 16'(c == 4'h3), 16'(uni));
      chk("dac", c == 4'h4 ? 16'h03FF : 16'h0000, 16'(dac));
      r1 = (c == 4'h1) ? 14'($random(seed)) : wnd(c) >> 14;
      r2 = wnd(c) + 28'h1;
      conv(r1);
      conv(r2);
      tick(1);
      rd_r(`DMC_A_DIAG1, d); chk("result one", {r1, 2'h0}, d);
      rd_r(`DMC_A_DIAG2, d); chk("result two", {r2, 2'h0}, d);
      rd_r(`DMC_A_STATUS, d);
      chk("pass", {13'h0, c == 4'h1, ep(c, r2), ep(c, r1)}, {13'h0, d[2:0]});
    end
    $display("diagnostic select test done");
    @(posedge clk);
    ms <= 1'h1;
    @(posedge clk);
    ms <= 1'h0;
    repeat (ST + 1) @(posedge clk);
    #1;
    chk("conv go", 16'h0001, 16'(go));
    tick(1); chk("conv go pulse", 16'h0000, 16'(go));
    $display("settle test done");
    wr_r(`DMC_A_DIAG_CONFIG_REG, 16'h0000);
    wr_r(`DMC_A_TEMP_TH, 16'h0100);
    tick(TI + 4);
    rd_r(`DMC_A_FAULT2, d); chk("no overtemp", 16'h0000, d);
    @(posedge clk);
    dtc <= 14'h0200;
    tick(TI + 4);
    rd_r(`DMC_A_FAULT2, d); chk("overtemp", 16'h0001, d);
    wr_r(`DMC_A_DIAG_CONFIG_REG, 16'h0010);
    wr_r(`DMC_A_FAULT2, 16'h0001);
    tick(2 * TI + 4);
    rd_r(`DMC_A_FAULT2, d); chk("overtemp held off", 16'h0000, d);
    $display("over temperature test done");
    @(posedge clk);
    dtc <= 14'h3000;
    tick(3); chk("no shutdown", 16'h0000, 16'(shut));
    @(posedge clk);
    dtc <= 14'h3001;
    tick(3); chk("shutdown", 16'h0001, 16'(shut));
    $display("shutdown test done");
    finish_test();
  end

  // Run takes several hundred cycles; 20000-cycle watchdog leaves a generous margin before giving up
  initial begin
    #200000;
    errors++;
    $display("Watchdog expired");
    finish_test();
  end
endmodule

// ===== verilog/dmc_diag_ctrl.v
// Diagnostic measurement control: alert pin test, open wire, die temp, diag selects
// What this block does
// [R1] Alert pin DC test active only in single UART mode with enable bit set.
// [R2] During DC test alert pin low when any alert present, else high.
// [R3] Writing the user alert bit sets or clears an alert condition.
// [R4] DC test works for every serial configuration, differential alert included.
// [R5] Host starts open wire check: open select set, comparator scan config 010.
// [R6] Open wire: flag comparator overvoltage bit for cells below open threshold.
// [R7] Open wire skips bipolar cells; their flags stay clear.
// [R8] Open modes enable pulldown currents on selected cells at chosen level.
// [R9] Die temperature above 145 C requests automatic shutdown.
// [R10] Select code 1 converts die temperature into result bits 15:2.
// [R11] Temperature conversion waits at least 39 us after cycle start.
// [R12] Die temperature checked against threshold every 1 ms; sets fault flag.
// [R13] Periodic over-temperature check suspended while either select requests code 1.
// [R14] Code 2 measures quarter reference on analog supply; pass A55 to BF4.
// [R15] Code 3 measures alternate reference and forces unipolar conversion.
// [R16] Alternate reference passes between 3247 and 341F, bounds reordered.
// [R17] Code D measures scaled logic regulator; pass 2147 to 24B6.
// [R18] Code 4 routes comparator path, threshold converter at 3FF.
// [R19] Comparator path result passes from 1F3F to 20BB.
// [R20] Host treats result as pass when inclusively inside the window.
`include "dmc_regs.vh"
module dmc_diag_ctrl #(
  parameter NCELL     = 14,
  parameter SETTLE    = `DMC_SETTLE_CYC,
  parameter TEMP_INT  = `DMC_TEMP_INT_CYC,
  parameter SHUT_CODE = 14'h3000
) (
  input  wire              clk,
  input  wire              rst,
  input  wire [3:0]        addr,
  input  wire [15:0]       wdata,
  input  wire              wr,
  input  wire              rd,
  output reg  [15:0]       rdata_q,
  input  wire              alert_any,
  input  wire [1:0]        serial_iface_config,
  input  wire [NCELL-1:0]  comp_cell_valid,
  input  wire [12*NCELL-1:0] comp_cell_value,
  input  wire              comp_scan_done,
  input  wire [13:0]       die_temp_code,
  input  wire              adc_done,
  input  wire [13:0]       adc_result,
  input  wire              meas_cycle_start,
  output reg               alert_out_pin_q,
  output reg               alert_out_oe_q,
  output reg  [NCELL-1:0]  pulldown_en_q,
  output reg  [2:0]        test_current_level_q,
  output reg               shutdown_q,
  output reg  [3:0]        adc_mux_sel_q,
  output reg               adc_ref_analog_q,
  output reg               adc_force_unipolar_q,
  output reg  [11:0]       threshold_dac_q,
  output reg               diag_conv_go_q
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  reg [7:0]       ctrl_q;
  reg [3:0]       diag_select_one_q;
  reg [3:0]       diag_select_two_q;
  reg [2:0]       scan_config_q;
  reg [11:0]      open_wire_threshold_q;
  reg [13:0]      temp_th_q;
  reg [NCELL-1:0] bipolar_q;
  reg [NCELL-1:0] test_current_enables_q;
  reg [NCELL-1:0] comparator_over_flags_q;
  reg             die_overtemp_flag_q;
  reg [15:0]      diag_result_one_q;
  reg [15:0]      diag_result_two_q;
  reg             scan_busy_q;
  reg [16:0]      settle_q;
  reg             conv_slot_q;
  reg [NCELL-1:0] open_hits;
  wire            temp_tick;
  wire            pass_one;
  wire            pass_two;
  integer         i;

  wire user_forced_alert   = ctrl_q[`DMC_CTRL_USERALR];
  wire serial_iface_select = ctrl_q[`DMC_CTRL_SERIAL_IFACE_SELECT];
  wire open_wire_diag_select = ctrl_q[`DMC_CTRL_OPENSEL];
  wire dc_test = serial_iface_select & ctrl_q[`DMC_CTRL_DCTSTEN];          // see [R1]
  wire temp_req = (diag_select_one_q == `DMC_SEL_TEMP_PROPORTIONAL_SOURCE) ||
                  (diag_select_two_q == `DMC_SEL_TEMP_PROPORTIONAL_SOURCE);
  wire open_mode = open_wire_diag_select && (scan_config_q == `DMC_SCAN_CONFIG_FIELD_COMP); // see [R5]
  wire wr_ctrl  = wr && (addr == `DMC_A_CTRL);
  wire wr_scan  = wr && (addr == `DMC_A_SCAN) && wdata[`DMC_SCAN_START];

  // ----------------------------------------------------------------------
  // 1 ms monitoring tick
  // ----------------------------------------------------------------------
  dmc_tick #(.WIDTH(17), .PERIOD(TEMP_INT)) u_tick (
    .clk    (clk),
    .rst    (rst),
    .tick_q (temp_tick)
  );

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q                 <= `DMC_RST_CTRL;
      diag_select_one_q      <= 4'h0;
      diag_select_two_q      <= 4'h0;
      test_current_level_q   <= 3'h0;
      scan_config_q          <= 3'h0;
      open_wire_threshold_q  <= `DMC_RST_OPEN_TH;
      temp_th_q              <= `DMC_RST_TEMP_TH;
      bipolar_q              <= {NCELL{1'b0}};
      test_current_enables_q <= {NCELL{1'b0}};
    end else if (wr) begin
      case (addr)
        `DMC_A_CTRL:    ctrl_q <= wdata[7:0];                             // see [R3]
        `DMC_A_DIAG_CONFIG_REG: begin
          diag_select_one_q    <= wdata[3:0];
          diag_select_two_q    <= wdata[7:4];
          test_current_level_q <= wdata[10:8];
        end
        `DMC_A_OPEN_TH: open_wire_threshold_q  <= wdata[11:0];
        `DMC_A_TEMP_TH: temp_th_q              <= wdata[13:0];
        `DMC_A_BIPOLAR: bipolar_q              <= wdata[NCELL-1:0];
        `DMC_A_CTST_EN: test_current_enables_q <= wdata[NCELL-1:0];
        `DMC_A_SCAN:    scan_config_q          <= wdata[3:1];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Alert pin DC test
  // ----------------------------------------------------------------------
  // Pin released otherwise; differential alert does not gate the test
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alert_out_pin_q <= 1'b1;
      alert_out_oe_q  <= 1'b0;
    end else begin
      alert_out_oe_q  <= dc_test;                                          // see [R4]
      alert_out_pin_q <= ~(alert_any | user_forced_alert);                 // see [R2] [R3]
    end
  end

  // ----------------------------------------------------------------------
  // Open wire detection
  // ----------------------------------------------------------------------
  always @* begin
    open_hits = {NCELL{1'b0}};
    for (i = 0; i < NCELL; i = i + 1) begin
      open_hits[i] = comp_cell_valid[i] && !bipolar_q[i] &&                // see [R7]
                     (comp_cell_value[12*i +: 12] < open_wire_threshold_q); // see [R6]
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      comparator_over_flags_q <= {NCELL{1'b0}};
      scan_busy_q             <= 1'b0;
      pulldown_en_q           <= {NCELL{1'b0}};
    end else begin
      if (wr_scan)
        scan_busy_q <= 1'b1;
      else if (comp_scan_done)
        scan_busy_q <= 1'b0;
      pulldown_en_q <= (open_mode && scan_busy_q) ?
                       test_current_enables_q : {NCELL{1'b0}};             // see [R8]
      // Write-one-to-clear; a new hit in the same cycle wins
      comparator_over_flags_q <= (comparator_over_flags_q &
          ~((wr && addr == `DMC_A_COMP_OV) ? wdata[NCELL-1:0] : {NCELL{1'b0}})) |
          ((open_mode && scan_busy_q) ? open_hits : {NCELL{1'b0}});
    end
  end

  // ----------------------------------------------------------------------
  // Die temperature alert and shutdown
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      die_overtemp_flag_q <= 1'b0;
      shutdown_q          <= 1'b0;
    end else begin
      if (temp_tick && !temp_req && die_temp_code > temp_th_q)              // see [R12] [R13]
        die_overtemp_flag_q <= 1'b1;
      else if (wr && addr == `DMC_A_FAULT2 && wdata[`DMC_FLT2_OVTEMP])
        die_overtemp_flag_q <= 1'b0;
      // Sticky until reset; die must cool and the device restart
      if (die_temp_code > SHUT_CODE)                                        // see [R9]
        shutdown_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Diagnostic conversion sequencing
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_q       <= 17'h00000;
      conv_slot_q    <= 1'b0;
      diag_conv_go_q <= 1'b0;
    end else begin
      diag_conv_go_q <= 1'b0;
      if (meas_cycle_start) begin
        settle_q    <= SETTLE[16:0];
        conv_slot_q <= 1'b1;
      end else if (settle_q != 17'h00000) begin
        settle_q <= settle_q - 17'h00001;
      end else if (conv_slot_q) begin
        conv_slot_q    <= 1'b0;
        diag_conv_go_q <= 1'b1;                                            // see [R11]
      end
    end
  end

  // Slot one converts first, then slot two after its done
  reg conv_two_q;
  wire [3:0] cur_sel = conv_two_q ? diag_select_two_q : diag_select_one_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_two_q           <= 1'b0;
      diag_result_one_q    <= 16'h0000;
      diag_result_two_q    <= 16'h0000;
      adc_mux_sel_q        <= 4'h0;
      adc_ref_analog_q     <= 1'b0;
      adc_force_unipolar_q <= 1'b0;
      threshold_dac_q      <= 12'h000;
    end else begin
      adc_mux_sel_q        <= cur_sel;                                      // see [R10]
      adc_ref_analog_q     <= (cur_sel == `DMC_SEL_VAA);                    // see [R14]
      adc_force_unipolar_q <= (cur_sel == `DMC_SEL_ALTERNATE_REFERENCE);                 // see [R15]
      threshold_dac_q      <= (cur_sel == `DMC_SEL_COMP) ? `DMC_DAC_FULL : 12'h000; // see [R18]
      if (adc_done) begin
        if (conv_two_q)
          diag_result_two_q <= {adc_result, 2'b00};                         // see [R10]
        else
          diag_result_one_q <= {adc_result, 2'b00};                         // see [R10]
        conv_two_q <= ~conv_two_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pass windows, shown in status
  // ----------------------------------------------------------------------
  function [27:0] win;
    input [3:0] sel;
    begin
      case (sel)
        `DMC_SEL_VAA:    win = {`DMC_VAA_LO,  `DMC_VAA_HI};                 // see [R14]
        `DMC_SEL_ALTERNATE_REFERENCE: win = {`DMC_ALT_LO,  `DMC_ALT_HI};                 // see [R16]
        `DMC_SEL_VDDL:   win = {`DMC_VDDL_LO, `DMC_VDDL_HI};                // see [R17]
        `DMC_SEL_COMP:   win = {`DMC_COMP_LO, `DMC_COMP_HI};                // see [R19]
        default:         win = {14'h0000, 14'h3FFF};
      endcase
    end
  endfunction

  wire [27:0] win_one = win(diag_select_one_q);
  wire [27:0] win_two = win(diag_select_two_q);

  dmc_window u_win_one (
    .value (diag_result_one_q[15:2]),
    .lo    (win_one[27:14]),
    .hi    (win_one[13:0]),
    .pass  (pass_one)
  );

  dmc_window u_win_two (
    .value (diag_result_two_q[15:2]),
    .lo    (win_two[27:14]),
    .hi    (win_two[13:0]),
    .pass  (pass_two)
  );

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (rd) begin
      case (addr)
        `DMC_A_CTRL:    rdata_q <= {8'h00, ctrl_q};
        `DMC_A_DIAG_CONFIG_REG: rdata_q <= {5'h00, test_current_level_q,
                                    diag_select_two_q, diag_select_one_q};
        `DMC_A_OPEN_TH: rdata_q <= {4'h0, open_wire_threshold_q};
        `DMC_A_TEMP_TH: rdata_q <= {2'h0, temp_th_q};
        `DMC_A_BIPOLAR: rdata_q <= {{(16-NCELL){1'b0}}, bipolar_q};
        `DMC_A_CTST_EN: rdata_q <= {{(16-NCELL){1'b0}}, test_current_enables_q};
        `DMC_A_SCAN:    rdata_q <= {12'h000, scan_config_q, scan_busy_q};
        `DMC_A_COMP_OV: rdata_q <= {{(16-NCELL){1'b0}}, comparator_over_flags_q};
        `DMC_A_FAULT2:  rdata_q <= {15'h0000, die_overtemp_flag_q};
        `DMC_A_DIAG1:   rdata_q <= diag_result_one_q;
        `DMC_A_DIAG2:   rdata_q <= diag_result_two_q;
        `DMC_A_STATUS:  rdata_q <= {11'h000, shutdown_q, dc_test, temp_req,
                                    pass_two, pass_one};
        default:        rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
endmodule

// ===== verilog/dmc_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef DMC_REGS_VH
`define DMC_REGS_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DMC_A_CTRL        4'h0
`define DMC_A_DIAG_CONFIG_REG     4'h1
`define DMC_A_OPEN_TH     4'h2
`define DMC_A_TEMP_TH     4'h3
`define DMC_A_BIPOLAR     4'h4
`define DMC_A_CTST_EN     4'h5
`define DMC_A_SCAN        4'h6
`define DMC_A_COMP_OV     4'h7
`define DMC_A_FAULT2      4'h8
`define DMC_A_DIAG1       4'h9
`define DMC_A_DIAG2       4'hA
`define DMC_A_STATUS      4'hB
// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define DMC_CTRL_SERIAL_IFACE_SELECT  0
`define DMC_CTRL_DCTSTEN  1
`define DMC_CTRL_USERALR  2
`define DMC_CTRL_OPENSEL  3
`define DMC_SCAN_START    0
`define DMC_FLT2_OVTEMP   0
`define DMC_SCAN_CONFIG_FIELD_COMP  3'h2
`define DMC_SEL_TEMP_PROPORTIONAL_SOURCE      4'h1
`define DMC_SEL_VAA       4'h2
`define DMC_SEL_ALTERNATE_REFERENCE    4'h3
`define DMC_SEL_COMP      4'h4
`define DMC_SEL_VDDL      4'hD
`define DMC_DAC_FULL      12'h3FF
// Pass windows on the 14-bit result
`define DMC_VAA_LO        14'h0A55
`define DMC_VAA_HI        14'h0BF4
`define DMC_ALT_LO        14'h3247
`define DMC_ALT_HI        14'h341F
`define DMC_VDDL_LO       14'h2147
`define DMC_VDDL_HI       14'h24B6
`define DMC_COMP_LO       14'h1F3F
`define DMC_COMP_HI       14'h20BB
// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define DMC_RST_CTRL      8'h00
`define DMC_RST_OPEN_TH   12'h000
`define DMC_RST_TEMP_TH   14'h3FFF
`define DMC_CLK_MHZ       100
`define DMC_SETTLE_US     39
`define DMC_SETTLE_CYC    (`DMC_SETTLE_US * `DMC_CLK_MHZ)
`define DMC_TEMP_INT_US   1000
`define DMC_TEMP_INT_CYC  (`DMC_TEMP_INT_US * `DMC_CLK_MHZ)
`define DMC_SHUT_TEMP_C   145
`endif

// ===== verilog/dmc_tick.v
// Free-running divider producing a one-cycle enable pulse
module dmc_tick #(
  parameter WIDTH  = 17,
  parameter PERIOD = 100000
) (
  input  wire clk,
  input  wire rst,
  output reg  tick_q
);
  reg [WIDTH-1:0] cnt_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= {WIDTH{1'b0}};
      tick_q <= 1'b0;
    end else if (cnt_q == PERIOD[WIDTH-1:0] - {{(WIDTH-1){1'b0}}, 1'b1}) begin
      cnt_q  <= {WIDTH{1'b0}};
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end
endmodule

// ===== verilog/dmc_window.v
// Inclusive range check of a 14-bit diagnostic result
module dmc_window (
  input  wire [13:0] value,
  input  wire [13:0] lo,
  input  wire [13:0] hi,
  output wire        pass
);
  assign pass = (value >= lo) && (value <= hi);
endmodule
